// File: src/cspf_params.svh
// Purpose: constants for the clock stop and power fail control block
// Assumes: core clock of 25 MHz
// Notes:   times are kept in their own unit, cycle counts derived
`ifndef CSPF_PARAMS_SVH
`define CSPF_PARAMS_SVH
`define CSPF_CLK_MHZ        25
`define CSPF_ONESHOT_US     1000
`define CSPF_ONESHOT_CYC    (`CSPF_ONESHOT_US * `CSPF_CLK_MHZ)
`define CSPF_PSW_WIDTH      16
`define CSPF_PSW_INTEN_BIT  1
`define CSPF_PSW_MACHINE_FAULT_BIT   2
`define CSPF_DIV_INIT       2'h0
`define CSPF_DIV_FIRE       2'h3
`define CSPF_HALF_WIDTH     16
`endif

// File: src/cspf_pkg.sv
// Purpose: types for the clock stop and power fail control block
// Assumes: nothing
// Notes:   states are one-hot
package cspf_pkg;
  typedef enum logic [2:0] {
    CSPF_OS_IDLE = 3'h1,
    CSPF_OS_RUN  = 3'h2,
    CSPF_OS_DONE = 3'h4
  } cspf_os_e;
  typedef logic [1:0] cspf_div_t;
endpackage

// File: src/cspf_sync_if.sv
// Purpose: carries a synchronised pin level and its edge pulses
// Assumes: one core clock domain
// Notes:   driven by the synchroniser, read by the control block
`timescale 1ns/1ns
interface cspf_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input  level, input  rise, input  fall);
endinterface

// File: src/cspf_sync.sv
// Purpose: three-flop synchroniser with agreement filter and edges
// Assumes: async pin input, core clock domain
// Notes:   first flop is read only by the second
`timescale 1ns/1ns
module cspf_sync (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic pin_i,
  cspf_sync_if.src  out
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       lvl_reg;
  logic       lvl_next;

  always_comb begin
    sh_next  = {sh_reg[1:0], pin_i};
    lvl_next = lvl_reg;
    if (sh_reg[1] == sh_reg[2]) begin
      lvl_next = sh_reg[1];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_reg  <= 3'h0;
      lvl_reg <= 1'h0;
    end else begin
      sh_reg  <= sh_next;
      lvl_reg <= lvl_next;
    end
  end

  assign out.level = lvl_reg;
  assign out.rise  = lvl_next & ~lvl_reg;
  assign out.fall  = ~lvl_next & lvl_reg;
endmodule

// File: src/cspf_ctrl.sv
// Purpose: clock enables, stop hierarchy, skip logic, system clear and power fail
// Assumes: one core clock; derived clocks are one-cycle enables
// Notes:   power_fail_detect is an async pin, synchronised here
`timescale 1ns/1ns
`include "cspf_params.svh"

// Functional notes
// RL1 - base clock is AND of two-bit counter
// RL2 - divider hold forces counter to initial state
// RL3 - every derived clock gated once from base
// RL4 - control phase loads sequencer; memory halt stops
// RL5 - microword strobe skipped during sequencer halt
// RL6 - memory timing clock never inhibited
// RL7 - destination halt suppresses destination clocks
// RL8 - memory halt stops all but memory clock
// RL9 - io halt stops all but control phase; code stops only strobe and destination clock
// RL10 - read or decode skips destination and strobe
// RL11 - branch: no destination; taken skips strobe
// RL12 - skip flop set, clears next base clock
// RL13 - system clear from off, key, detect
// RL14 - system clear resets memory, bus; until power good
// RL15 - detect fires one millisecond timer, sets warning
// RL16 - timer trailing edge sets power fail
// RL17 - fault from warning with bit2, or loss
// RL18 - reset parity clears warning and parity error
// RL19 - odd parity per halfword, error raises fault
// RL20 - load status copies buffered warning to less-than
// RL21 - attention ignored until status bit1 set
// RL22 - power up swap: bit2, autorestart, run
// RL23 - detect input synchronised before use
module cspf_ctrl #(
  parameter int ONESHOT_CYC = `CSPF_ONESHOT_CYC
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        nrst_i,
  input  wire logic                        divider_hold_i,
  input  wire logic                        memory_halt_i,
  input  wire logic                        io_halt_i,
  input  wire logic                        sequencer_halt_i,
  input  wire logic                        destination_halt_i,
  input  wire logic                        op_branch_i,
  input  wire logic                        op_decode_i,
  input  wire logic                        op_instr_read_i,
  input  wire logic                        branch_taken_i,
  input  wire logic                        power_off_i,
  input  wire logic                        init_key_i,
  input  wire logic                        supplies_ok_i,
  input  wire logic                        power_fail_detect_i,
  input  wire logic                        reset_parity_command_i,
  input  wire logic                        load_status_strobe_i,
  input  wire logic [`CSPF_PSW_WIDTH-1:0]  program_status_word_i,
  input  wire logic                        parity_option_i,
  input  wire logic                        mem_write_i,
  input  wire logic                        mem_read_i,
  input  wire logic [`CSPF_HALF_WIDTH-1:0] mem_wdata_i,
  input  wire logic [`CSPF_HALF_WIDTH-1:0] mem_rdata_i,
  input  wire logic                        mem_rparity_i,
  input  wire logic                        device_irq_i,
  input  wire logic                        irq_ack_i,
  input  wire logic                        auto_restart_i,
  input  wire logic                        run_mode_i,
  output logic                             base_clock_o,
  output logic                             control_phase_clock_o,
  output logic                             sequencer_address_load_o,
  output logic                             microword_strobe_o,
  output logic                             memory_timing_clock_o,
  output logic                             destination_clock_o,
  output logic                             skip_o,
  output logic                             system_clear_o,
  output logic                             early_power_warning_o,
  output logic                             buffered_early_warning_o,
  output logic                             power_fail_o,
  output logic                             primary_power_loss_o,
  output logic                             machine_fault_o,
  output logic                             less_than_flag_o,
  output logic                             mem_wparity_o,
  output logic                             parity_error_o,
  output logic                             io_attention_o,
  output logic                             powerup_swap_o
);

  // ****************************************
  // detect input synchroniser
  // ****************************************
  cspf_sync_if pfd_if ();

  // RL23 synchronise detect input
  cspf_sync u_pfd_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .pin_i      (power_fail_detect_i),
    .out        (pfd_if)
  );

  // ****************************************
  // divider and derived clock enables
  // ****************************************
  cspf_pkg::cspf_div_t div_reg;
  cspf_pkg::cspf_div_t div_next;
  logic                skip_reg;
  logic                skip_next;
  logic                base;
  logic                skip_op;

  always_comb begin
    // RL2 hold divider at initial state
    if (divider_hold_i) begin
      div_next = `CSPF_DIV_INIT;
    end else begin
      div_next = div_reg + 2'h1;
    end
  end

  // RL1 base clock from counter AND
  assign base    = div_reg[0] & div_reg[1] & ~divider_hold_i;
  assign skip_op = op_decode_i | op_instr_read_i | (op_branch_i & branch_taken_i);

  always_comb begin
    skip_next = skip_reg;
    if (base) begin
      // RL12 set on skip ops, clear next base
      skip_next = skip_reg ? 1'h0 : skip_op;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg  <= `CSPF_DIV_INIT;
      skip_reg <= 1'h0;
    end else begin
      div_reg  <= div_next;
      skip_reg <= skip_next;
    end
  end

  // RL3 single gate on base clock
  // RL6 memory clock uninhibited
  assign memory_timing_clock_o    = base;
  // RL4 control phase stopped by memory halt
  // RL9 io halt leaves control phase running
  assign control_phase_clock_o    = base & ~memory_halt_i;
  assign sequencer_address_load_o = base & ~memory_halt_i
                                    & (op_branch_i | op_decode_i | op_instr_read_i);
  // RL5 strobe skipped on sequencer halt
  // RL8 memory halt stops strobe
  // RL10 first cycle of read or decode skipped
  // RL11 taken branch skips a strobe
  assign microword_strobe_o       = base & ~memory_halt_i & ~io_halt_i & ~sequencer_halt_i
                                    & (skip_reg | ~skip_op);
  // RL7 destination halt suppresses
  // RL11 branch has no destination clock
  assign destination_clock_o      = base & ~memory_halt_i & ~io_halt_i & ~destination_halt_i
                                    & ~op_branch_i & (skip_reg | ~skip_op);
  assign base_clock_o             = base;
  assign skip_o                   = skip_reg;

  // ****************************************
  // one millisecond timer and power flags
  // ****************************************
  cspf_pkg::cspf_os_e os_reg;
  cspf_pkg::cspf_os_e os_next;
  logic [31:0]        cnt_reg;
  logic [31:0]        cnt_next;
  logic               epw_reg;
  logic               epw_next;
  logic               bepw_reg;
  logic               bepw_next;
  logic               pf_reg;
  logic               pf_next;
  logic               perr_reg;
  logic               perr_next;
  logic               lt_reg;
  logic               lt_next;
  logic               atn_reg;
  logic               atn_next;
  logic               rd_par;

  assign rd_par = ~^mem_rdata_i;

  always_comb begin
    os_next   = os_reg;
    cnt_next  = cnt_reg;
    epw_next  = epw_reg;
    pf_next   = pf_reg;
    perr_next = perr_reg;
    lt_next   = lt_reg;
    atn_next  = atn_reg;
    bepw_next = epw_reg;
    case (os_reg)
      cspf_pkg::CSPF_OS_IDLE: begin
        if (pfd_if.rise) begin
          os_next  = cspf_pkg::CSPF_OS_RUN;
          cnt_next = 32'h0;
        end
      end
      cspf_pkg::CSPF_OS_RUN: begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg == ONESHOT_CYC - 1) begin
          os_next = cspf_pkg::CSPF_OS_DONE;
          // RL16 trailing edge sets power fail
          pf_next = 1'h1;
        end
      end
      cspf_pkg::CSPF_OS_DONE: begin
        if (!pfd_if.level) begin
          os_next = cspf_pkg::CSPF_OS_IDLE;
        end
      end
      default: os_next = cspf_pkg::CSPF_OS_IDLE;
    endcase
    // RL18 reset parity clears warning, set wins
    if (reset_parity_command_i) begin
      epw_next  = 1'h0;
      perr_next = 1'h0;
    end
    // RL15 leading edge sets warning
    if (os_reg == cspf_pkg::CSPF_OS_IDLE && pfd_if.rise) begin
      epw_next = 1'h1;
    end
    // RL19 read parity check
    if (parity_option_i && mem_read_i && (rd_par != mem_rparity_i)) begin
      perr_next = 1'h1;
    end
    // RL20 copy buffered warning on load status
    if (load_status_strobe_i) begin
      lt_next = bepw_reg;
    end
    // RL21 attention pending until enabled and acknowledged
    if (irq_ack_i && program_status_word_i[`CSPF_PSW_INTEN_BIT]) begin
      atn_next = 1'h0;
    end
    if (device_irq_i) begin
      atn_next = 1'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      os_reg   <= cspf_pkg::CSPF_OS_IDLE;
      cnt_reg  <= 32'h0;
      epw_reg  <= 1'h0;
      bepw_reg <= 1'h0;
      pf_reg   <= 1'h0;
      perr_reg <= 1'h0;
      lt_reg   <= 1'h0;
      atn_reg  <= 1'h0;
    end else begin
      os_reg   <= os_next;
      cnt_reg  <= cnt_next;
      epw_reg  <= epw_next;
      bepw_reg <= bepw_next;
      pf_reg   <= pf_next;
      perr_reg <= perr_next;
      lt_reg   <= lt_next;
      atn_reg  <= atn_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // RL13 clear sources
  // RL14 held until supplies good
  assign system_clear_o = power_off_i | init_key_i | pfd_if.level | ~supplies_ok_i | ~nrst_i;
  // RL19 odd write parity
  assign mem_wparity_o  = parity_option_i & mem_write_i & ~^mem_wdata_i;
  // RL17 fault equation
  assign machine_fault_o = ((epw_reg | perr_reg) & program_status_word_i[`CSPF_PSW_MACHINE_FAULT_BIT])
                           | pf_reg;
  // RL21 gate attention by status bit 1
  assign io_attention_o  = atn_reg & program_status_word_i[`CSPF_PSW_INTEN_BIT];
  // RL22 power up swap condition
  assign powerup_swap_o  = program_status_word_i[`CSPF_PSW_MACHINE_FAULT_BIT] & auto_restart_i
                           & run_mode_i;
  assign early_power_warning_o    = epw_reg;
  assign buffered_early_warning_o = bepw_reg;
  assign power_fail_o             = pf_reg;
  assign primary_power_loss_o     = pf_reg;
  assign parity_error_o           = perr_reg;
  assign less_than_flag_o         = lt_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_div_hold: assert property (divider_hold_i |=> div_reg == 2'h0 && !base) // RL2
    else $error("divider not held");
  a_base_period: assert property (base ##1 !divider_hold_i [*4] // RL1
    |-> base && !$past(base) && !$past(base, 2) && !$past(base, 3))
    else $error("base clock period wrong");
  a_mem_clk_free: assert property (memory_timing_clock_o == base) // RL6
    else $error("memory clock gated");
  a_mhalt_stop: assert property (memory_halt_i |-> !control_phase_clock_o // RL8
    && !microword_strobe_o && !destination_clock_o)
    else $error("memory halt leak");
  a_iohalt_cp: assert property (io_halt_i && base && !memory_halt_i // RL9
    |-> control_phase_clock_o && !microword_strobe_o)
    else $error("io halt wrong");
  a_dhalt_stop: assert property (destination_halt_i |-> !destination_clock_o) // RL7
    else $error("destination halt leak");
  a_skip_clear: assert property (skip_reg && base |=> !skip_reg) // RL12
    else $error("skip not cleared");
  a_skip_strobe: assert property (base && skip_op && !skip_reg |-> !microword_strobe_o) // RL10
    else $error("strobe not skipped");
  a_branch_dest: assert property (op_branch_i |-> !destination_clock_o) // RL11
    else $error("branch destination clock");
  a_warn_set: assert property (os_reg == cspf_pkg::CSPF_OS_IDLE && pfd_if.rise // RL15
    |=> epw_reg && os_reg == cspf_pkg::CSPF_OS_RUN)
    else $error("warning not set");
  a_fault_eq: assert property (pf_reg |-> machine_fault_o) // RL17
    else $error("fault missing");
  a_rpar_clr: assert property (reset_parity_command_i && !pfd_if.rise |=> !epw_reg) // RL18
    else $error("warning not cleared");

  c_skip_seq: cover property (base && op_decode_i ##4 base && skip_reg);
  c_warn: cover property (pfd_if.rise ##1 epw_reg);
  c_pfail: cover property (!pf_reg ##1 pf_reg);
endmodule

// File: bench/cspf_far_model.sv
// Purpose: memory and power fail detector beside the control block
// Assumes: one core clock; detector pin moves off the clock edge
// Notes:   read data is inverted while the bus is released
`timescale 1ns/1ns
module cspf_far_model (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        fail_i,
  input  wire logic        bad_par_i,
  input  wire logic        mem_write_i,
  input  wire logic        mem_read_i,
  input  wire logic [15:0] mem_wdata_i,
  output logic             detect_o,
  output logic [15:0]      mem_rdata_o,
  output logic             mem_rparity_o
);
  logic [15:0] store_reg;
  // ********************
  // memory and detector
  // ********************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) store_reg <= 16'h0;
    else if (mem_write_i) store_reg <= mem_wdata_i;
  end
  // async pin, skewed from the clock
  assign #7 detect_o = fail_i;
  assign mem_rdata_o = mem_read_i ? store_reg : ~store_reg;
  assign mem_rparity_o = (~^store_reg) ^ bad_par_i ^ !mem_read_i;
endmodule

// File: bench/cspf_ctrl_tb.sv
// Purpose: self-checking bench for the clock stop and power fail block
// Assumes: 25 MHz core clock, one-shot shortened to 20 cycles
// Notes:   enables are sampled at the falling edge of the base cycle
`timescale 1ns/1ns
`include "cspf_params.svh"
module cspf_ctrl_tb;
  localparam int OS = 20;
  logic core_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic dh = 0, mh = 0, ih = 0, sh = 0, th = 0, br = 0, dc = 0, ir = 0, bt = 0;
  logic off = 0, key = 0, sok = 1, fail = 0, rpc = 0, lss = 0, po = 0, mw = 0, mr = 0;
  logic irq = 0, ack = 0, ar = 0, run = 0, bad = 0;
  logic [15:0] program_status_word = 16'h0, wd = 16'h0, rd;
  logic det, rpar, bc, cp, sal, sw, mt, dst, skp, sc, epw, bepw, pf, ppl, mf, lt, wp, pe;
  logic att, swp;
  int mismatches = 0;
  int n_checks = 0;
  int i;
  cspf_ctrl #(.ONESHOT_CYC(OS)) DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .divider_hold_i(dh), .memory_halt_i(mh), .io_halt_i(ih), .sequencer_halt_i(sh),
    .destination_halt_i(th), .op_branch_i(br), .op_decode_i(dc), .op_instr_read_i(ir),
    .branch_taken_i(bt), .power_off_i(off), .init_key_i(key), .supplies_ok_i(sok),
    .power_fail_detect_i(det), .reset_parity_command_i(rpc), .load_status_strobe_i(lss),
    .program_status_word_i(program_status_word), .parity_option_i(po), .mem_write_i(mw), .mem_read_i(mr),
    .mem_wdata_i(wd), .mem_rdata_i(rd), .mem_rparity_i(rpar), .device_irq_i(irq),
    .irq_ack_i(ack), .auto_restart_i(ar), .run_mode_i(run), .base_clock_o(bc),
    .control_phase_clock_o(cp), .sequencer_address_load_o(sal), .microword_strobe_o(sw),
    .memory_timing_clock_o(mt), .destination_clock_o(dst), .skip_o(skp),
    .system_clear_o(sc), .early_power_warning_o(epw), .buffered_early_warning_o(bepw),
    .power_fail_o(pf), .primary_power_loss_o(ppl), .machine_fault_o(mf),
    .less_than_flag_o(lt), .mem_wparity_o(wp), .parity_error_o(pe),
    .io_attention_o(att), .powerup_swap_o(swp));
  cspf_far_model far (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .fail_i(fail),
    .bad_par_i(bad), .mem_write_i(mw), .mem_read_i(mr), .mem_wdata_i(wd),
    .detect_o(det), .mem_rdata_o(rd), .mem_rparity_o(rpar));
  always #20 core_clk_i = ~core_clk_i;
  // ********************
  // helpers
  // ********************
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic base();
    int k;
    k = 0;
    @(negedge core_clk_i);
    while (bc !== 1'h1 && k < 8) begin
      @(negedge core_clk_i);
      k++;
    end
    if (k == 8) check("base_wait", 16'h0, 16'h1);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic halt_case(input logic [3:0] h, input logic [3:0] e, input logic [3:0] m);
    {mh, ih, sh, th} = h;
    base();
    check("halt_clocks", {cp, sw, dst, mt} & m, e & m);
    cyc(1);
  endtask
  task automatic op_case(input logic [3:0] op, input logic [1:0] e1, input logic two,
                         input logic [1:0] e2);
    {dc, ir, br, bt} = op;
    base();
    check("op_first", {sw, dst}, e1);
    check("addr_load", sal, op[3] | op[2] | op[1]);
    if (two) begin
      base();
      check("op_second", {sw, dst, skp}, {e2, 1'h1});
    end
    cyc(1);
    {dc, ir, br, bt} = 4'h0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #80000;
    mismatches++;
    final_report();
  end
  // ********************
  // tests
  // ********************
  initial begin
    cyc(4);
    check("system_clear_reset", sc, 1'h1);
    nrst_i = 1'h1;
    base();
    i = 0;
    do begin
      @(negedge core_clk_i);
      i++;
    end while (bc !== 1'h1 && i < 8);
    check("base_period", i, 16'h4);
    cyc(1);
    dh = 1'h1;
    cyc(1);
    repeat (8) begin
      @(negedge core_clk_i);
      check("held_clocks", {bc, mt}, 2'h0);
    end
    cyc(1);
    dh = 1'h0;
    done("divider");
    halt_case(4'h0, 4'hF, 4'hF);
    halt_case(4'h8, 4'h1, 4'hF);
    halt_case(4'h4, 4'h8, 4'hE);
    halt_case(4'h2, 4'h0, 4'h4);
    halt_case(4'h1, 4'h0, 4'h2);
    {mh, ih, sh, th} = 4'h0;
    done("halts");
    op_case(4'h8, 2'h0, 1'h1, 2'h3);
    op_case(4'h4, 2'h0, 1'h1, 2'h3);
    op_case(4'h3, 2'h0, 1'h1, 2'h2);
    op_case(4'h2, 2'h2, 1'h0, 2'h0);
    done("skips");
    fail = 1'h1;
    i = 0;
    while (epw !== 1'h1 && i < 12) begin
      cyc(1);
      i++;
    end
    check("epw_set", epw, 1'h1);
    check("system_clear_detect", sc, 1'h1);
    check("fault_masked", mf, 1'h0);
    check("pf_early", pf, 1'h0);
    cyc(1);
    check("bepw_set", bepw, 1'h1);
    program_status_word[`CSPF_PSW_MACHINE_FAULT_BIT] = 1'h1;
    lss = 1'h1;
    cyc(1);
    lss = 1'h0;
    check("fault_epw", mf, 1'h1);
    check("less_than", lt, 1'h1);
    rpc = 1'h1;
    cyc(1);
    rpc = 1'h0;
    check("epw_clear", epw, 1'h0);
    check("fault_gone", mf, 1'h0);
    cyc(2);
    lss = 1'h1;
    cyc(1);
    lss = 1'h0;
    check("less_than_clr", lt, 1'h0);
    program_status_word = 16'h0;
    i = 0;
    while (pf !== 1'h1 && i < OS + 8) begin
      cyc(1);
      i++;
    end
    check("pf_delay", i >= OS - 8, 1'h1);
    check("pf_set", {pf, ppl, mf}, 3'h7);
    fail = 1'h0;
    nrst_i = 1'h0;
    cyc(4);
    nrst_i = 1'h1;
    cyc(2);
    done("power_fail");
    po = 1'h1;
    program_status_word = 16'h0004;
    for (int j = 0; j < 16; j++) begin
      mw = 1'h1;
      wd = 16'hA5C3 ^ (16'h1 << j);
      @(negedge core_clk_i);
      check("wparity", wp, ~^wd);
      cyc(1);
    end
    mw = 1'h0;
    bad = 1'h1;
    mr = 1'h1;
    cyc(1);
    mr = 1'h0;
    check("perr_fault", {pe, mf}, 2'h3);
    rpc = 1'h1;
    cyc(1);
    rpc = 1'h0;
    bad = 1'h0;
    mr = 1'h1;
    cyc(1);
    mr = 1'h0;
    check("perr_good", {pe, mf}, 2'h0);
    done("parity");
    program_status_word = 16'h0;
    irq = 1'h1;
    cyc(1);
    irq = 1'h0;
    ack = 1'h1;
    cyc(1);
    ack = 1'h0;
    check("atn_masked", att, 1'h0);
    program_status_word[`CSPF_PSW_INTEN_BIT] = 1'h1;
    cyc(1);
    check("atn_pending", att, 1'h1);
    ack = 1'h1;
    cyc(1);
    ack = 1'h0;
    check("atn_ack", att, 1'h0);
    done("attention");
    for (i = 0; i < 4; i++) begin
      {off, key, sok} = {i == 1, i == 2, i != 3};
      @(negedge core_clk_i);
      check("system_clear_cause", sc, i != 0);
      cyc(1);
    end
    for (i = 0; i < 8; i++) begin
      {program_status_word[`CSPF_PSW_MACHINE_FAULT_BIT], ar, run} = i[2:0];
      @(negedge core_clk_i);
      check("swap", swp, i == 7);
      cyc(1);
    end
    done("init");
    final_report();
  end
endmodule
